// ---- gppr_responder.sv ----
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module gppr_responder
    import gppr_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              idy_i,
    input  wire logic              srqs_i,
    input  wire gppr_ctl_t         ctl_i,
    output logic      [7:0]        ppr_msg_o,
    output logic      [7:0]        ppr_oe_n_o
);

    localparam int unsigned NLINES = 1 << LINE_W;

    localparam logic [ADDR_W-1:0] ADDR_PORT =
        ADDR_W'({IDX_PORT, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_STATUS =
        ADDR_W'({IDX_STATUS, 2'b00});

    initial begin
        if (ADDR_W < 10) begin
            $error("gppr_responder: address too narrow for the map");
        end
        if (NLINES != 8) begin
            $error("gppr_responder: eight poll lines are assumed");
        end
    end

    // bus side
    logic              setup;
    logic              access;
    logic              hit_port;
    logic              hit_stat;
    logic              wr_port;
    logic [7:0]        wbyte;
    logic              is_ppr;
    logic              is_status_source_select_config;
    logic              is_poll_mode_secondary_config;
    logic              is_cmd;
    logic [31:0]       prdata_r;
    logic              pslverr_r;

    // configuration state
    logic              iss_r;
    logic              mode2_r;
    logic              mode1_r;
    logic              lsense_r;
    logic [LINE_W-1:0] lline_r;
    logic              flag_r;
    logic              rcfg_r;
    logic              rsense_r;
    logic [LINE_W-1:0] rline_r;

    // poll engine
    logic              idy_s;
    gppr_mode_t        mode;
    logic              cfg_on;
    logic              eff_sense;
    logic [LINE_W-1:0] eff_line;
    logic              ist;
    logic              msg_bit;
    logic              ppe_ok;
    gppr_state_t       state_r;
    gppr_state_t       state_nxt;
    logic [7:0]        onehot;
    logic [7:0]        ppr_msg_r;
    logic [7:0]        ppr_oe_n_r;
    gppr_status_t      status;

    // idy comes off the bus pins, so it is brought into our clock first
    gppr_sync #(
        .W (1)
    ) u_idy_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (idy_i),
        .sync_o  (idy_s)
    );

    // apb decode; one shared write port, one status word
    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i;
    assign hit_port = (paddr_i == ADDR_PORT);
    assign hit_stat = (paddr_i == ADDR_STATUS);
    assign wr_port  = access & pwrite_i & hit_port & pstrb_i[0];
    assign wbyte    = pwdata_i[7:0];

    // the top bits of the byte say which register it lands in
    assign is_ppr   = wr_port & ((wbyte & PPR_MASK) == PPR_VAL);
    assign is_status_source_select_config = wr_port & ((wbyte & STATUS_SOURCE_SELECT_CONFIG_MASK) == STATUS_SOURCE_SELECT_CONFIG_VAL);
    assign is_poll_mode_secondary_config = wr_port & ((wbyte & POLL_MODE_SECONDARY_CONFIG_MASK) == POLL_MODE_SECONDARY_CONFIG_VAL);
    assign is_cmd   = wr_port & ((wbyte & CMD_MASK) == CMD_VAL);

    // zero wait states: data is fetched in setup so it comes from a flop
    assign pready_o  = access;
    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= 32'h0000_0000;
            // port reads as zero, it is write-only; status is read-only
            pslverr_r <= ~(hit_port | (hit_stat & ~pwrite_i));
            if (hit_stat & ~pwrite_i) begin
                prdata_r <= 32'(status);
            end
        end
    end

    // status source select; other bits of this register belong elsewhere
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            iss_r <= STATUS_SOURCE_SELECT_CONFIG_RST[ISS_BIT];
        end else if (is_status_source_select_config) begin
            iss_r <= wbyte[ISS_BIT];
        end
    end

    // secondary mode bit
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mode2_r <= POLL_MODE_SECONDARY_CONFIG_RST[MODE2_BIT];
        end else if (is_poll_mode_secondary_config) begin
            mode2_r <= wbyte[MODE2_BIT];
        end
    end

    // primary mode bit with local sense and line field
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mode1_r  <= PPR_RST[MODE1_BIT];
            lsense_r <= PPR_RST[SENSE_BIT];
            lline_r  <= PPR_RST[LINE_LSB +: LINE_W];
        end else if (is_ppr) begin
            mode1_r  <= wbyte[MODE1_BIT];
            lsense_r <= wbyte[SENSE_BIT];
            lline_r  <= wbyte[LINE_LSB +: LINE_W];
        end
    end

    // poll flag; only software touches it, so no set/clear race exists
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flag_r <= FLAG_RST;
        end else if (is_cmd && wbyte == CMD_IST_SET) begin
            flag_r <= 1'b1;
        end else if (is_cmd && wbyte == CMD_IST_CLR) begin
            flag_r <= 1'b0;
        end
    end

    // mode decode: primary bit wins over the secondary one
    always_comb begin
        if (mode1_r) begin
            mode = GPPR_DISABLED;
        end else if (mode2_r) begin
            mode = GPPR_LOCAL;
        end else begin
            mode = GPPR_REMOTE;
        end
    end

    // controller enable is only taken while in remote mode; a disable is taken in any mode
    assign ppe_ok = ctl_i.ppe & ~ctl_i.ppd & (mode == GPPR_REMOTE) &
                    ((ctl_i.cmd_byte & PPE_MASK) == PPE_VAL);

    // remote assignment; disable wins so a late disable is never lost
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rcfg_r   <= 1'b0;
            rsense_r <= 1'b0;
            rline_r  <= '0;
        end else if (ctl_i.ppd) begin
            rcfg_r   <= 1'b0;
        end else if (ppe_ok) begin
            rcfg_r   <= 1'b1;
            rsense_r <= ctl_i.cmd_byte[SENSE_BIT];
            rline_r  <= ctl_i.cmd_byte[LINE_LSB +: LINE_W];
        end
    end

    // effective configuration; local mode looks like a 0x6n enable
    always_comb begin
        cfg_on    = 1'b0;
        eff_sense = 1'b0;
        eff_line  = '0;
        unique case (mode)
            GPPR_REMOTE: begin
                cfg_on    = rcfg_r;
                eff_sense = rsense_r;
                eff_line  = rline_r;
            end
            GPPR_LOCAL: begin
                cfg_on    = 1'b1;
                eff_sense = lsense_r;
                eff_line  = lline_r;
            end
            GPPR_DISABLED: begin
                cfg_on    = 1'b0;
            end
            default: begin
                cfg_on    = 1'b0;
            end
        endcase
    end

    // srqs_i is high exactly while our srq driver pulls the line
    assign ist     = iss_r ? srqs_i : flag_r;
    assign msg_bit = ~(ist ^ eff_sense);
    assign onehot  = 8'(1 << eff_line);

    // poll state: idle unconfigured, standby configured, active in a poll
    always_comb begin
        state_nxt = PP_IDLE;
        unique case (state_r)
            PP_IDLE, PP_STANDBY, PP_ACTIVE: begin
                if (!cfg_on) begin
                    state_nxt = PP_IDLE;
                end else if (idy_s) begin
                    state_nxt = PP_ACTIVE;
                end else begin
                    state_nxt = PP_STANDBY;
                end
            end
            default: begin
                state_nxt = PP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= PP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pin drivers follow the next state so they move with it in one edge
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ppr_msg_r  <= 8'h00;
            ppr_oe_n_r <= 8'hFF;
        end else if (state_nxt == PP_ACTIVE) begin
            ppr_msg_r  <= msg_bit ? onehot : 8'h00;
            ppr_oe_n_r <= ~onehot;
        end else begin
            ppr_msg_r  <= 8'h00;
            ppr_oe_n_r <= 8'hFF;
        end
    end

    assign ppr_msg_o  = ppr_msg_r;
    assign ppr_oe_n_o = ppr_oe_n_r;

    // readback picture of the engine
    assign status.line       = eff_line;
    assign status.sense      = eff_sense;
    assign status.mode       = mode;
    assign status.active     = (state_r == PP_ACTIVE);
    assign status.configured = cfg_on;
    assign status.ist        = ist;
    assign status.srqs       = srqs_i;
    assign status.flag       = flag_r;

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_poll_req;
        idy_s && cfg_on;
    endsequence

    sequence s_ppe_remote;
        ppe_ok ##1 !ctl_i.ppd;
    endsequence

    a_one_line_only: assert property (
        $countones(~ppr_oe_n_o) <= 1)
        else $error("more than one poll line driven");

    a_disabled_silent: assert property (
        mode1_r && $past(mode1_r) |-> ppr_oe_n_o == 8'hFF)
        else $error("poll answered while disabled");

    a_idy_release: assert property (
        !idy_s |=> ppr_oe_n_o == 8'hFF)
        else $error("poll line held after idy");

    a_poll_drive: assert property (
        s_poll_req |=> ppr_oe_n_o == ~$past(onehot))
        else $error("wrong poll line driven");

    a_poll_value: assert property (
        s_poll_req |=> ppr_msg_o[$past(eff_line)] ==
                      ($past(ist) == $past(eff_sense)))
        else $error("poll value does not follow sense");

    a_flag_set: assert property (
        is_cmd && wbyte == CMD_IST_SET |=> flag_r ##1 status.flag)
        else $error("poll flag not set");

    a_flag_clear: assert property (
        is_cmd && wbyte == CMD_IST_CLR |=> !flag_r)
        else $error("poll flag not cleared");

    a_remote_latch: assert property (
        s_ppe_remote |-> rcfg_r && rsense_r == $past(ctl_i.cmd_byte[3],1)
                         && rline_r == $past(ctl_i.cmd_byte[2:0],1))
        else $error("remote line and sense not latched");

    a_local_map: assert property (
        mode == GPPR_LOCAL && idy_s |=>
            ppr_oe_n_o == ~(8'h01 << $past(lline_r)) &&
            ppr_msg_o[$past(lline_r)] == ($past(ist) == $past(lsense_r)))
        else $error("local config not applied");

    a_source_sel: assert property (
        s_poll_req ##0 iss_r |=> ppr_msg_o[$past(eff_line)] ==
                                 ($past(srqs_i) == $past(eff_sense)))
        else $error("ist from wrong source");

    a_flag_source: assert property (
        s_poll_req ##0 !iss_r |=> ppr_msg_o[$past(eff_line)] ==
                                  ($past(flag_r) == $past(eff_sense)))
        else $error("poll flag not used as ist");

    a_port_split: assert property (
        wr_port && wbyte[7:5] == 3'b011 |=> mode1_r == $past(wbyte[4]))
        else $error("poll config byte not taken");

endmodule
`default_nettype wire

// ---- gppr_pkg.sv ----
// Summary of operation
// - on idy a configured device answers on exactly one of eight poll lines
// - mode bits: 00 remote, 01 local, primary set means disabled
// - primary mode bit set: no parallel poll answer at all
// - remote mode: controller's enable command assigns the poll line
// - remote mode: sense latched with the line from that same command
// - status source select bit 4 picks poll flag or service request
// - line value is source inverted for sense 0, source for sense 1
// - command 0x01 sets the poll flag, 0x09 clears it
// - service request state true exactly while srq is being driven
// - local mode: sense bit and three-bit field pick line 1 to 8
// - local mode acts like an enable command 0x6n with n the field
// - four write-only registers share one offset, split by high bits
package gppr_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_PORT   = 8'h0A;
    localparam logic [7:0] IDX_STATUS = 8'h0B;

    // high-bit patterns that steer a byte written to the shared port
    localparam logic [7:0] PPR_MASK   = 8'hE0;
    localparam logic [7:0] PPR_VAL    = 8'h60;
    localparam logic [7:0] STATUS_SOURCE_SELECT_CONFIG_MASK = 8'hE0;
    localparam logic [7:0] STATUS_SOURCE_SELECT_CONFIG_VAL  = 8'hA0;
    localparam logic [7:0] POLL_MODE_SECONDARY_CONFIG_MASK = 8'hF0;
    localparam logic [7:0] POLL_MODE_SECONDARY_CONFIG_VAL  = 8'hE0;
    localparam logic [7:0] CMD_MASK   = 8'hA0;
    localparam logic [7:0] CMD_VAL    = 8'h00;

    // enable command group seen from the controller
    localparam logic [7:0] PPE_MASK   = 8'hF0;
    localparam logic [7:0] PPE_VAL    = 8'h60;

    // field positions
    localparam int unsigned ISS_BIT   = 4;
    localparam int unsigned MODE2_BIT = 2;
    localparam int unsigned MODE1_BIT = 4;
    localparam int unsigned SENSE_BIT = 3;
    localparam int unsigned LINE_LSB  = 0;
    localparam int unsigned LINE_W    = 3;

    // auxiliary commands
    localparam logic [7:0] CMD_IST_SET = 8'h01;
    localparam logic [7:0] CMD_IST_CLR = 8'h09;

    // values after reset
    localparam logic [7:0] STATUS_SOURCE_SELECT_CONFIG_RST = 8'hA0;
    localparam logic [7:0] POLL_MODE_SECONDARY_CONFIG_RST = 8'hE0;
    localparam logic [7:0] AUXILIARY_COMMAND_PORT_RST = 8'h00;
    localparam logic [7:0] PPR_RST   = 8'h60;
    localparam logic       FLAG_RST  = 1'b0;

    typedef enum logic [1:0] {
        GPPR_REMOTE,
        GPPR_LOCAL,
        GPPR_DISABLED
    } gppr_mode_t;

    typedef enum logic [1:0] {
        PP_IDLE,
        PP_STANDBY,
        PP_ACTIVE
    } gppr_state_t;

    // decoded controller commands, one-cycle strobes on the system clock
    typedef struct packed {
        logic       ppe;
        logic       ppd;
        logic [7:0] cmd_byte;
    } gppr_ctl_t;

    // readback of the block's own state
    typedef struct packed {
        logic [LINE_W-1:0] line;
        logic              sense;
        gppr_mode_t        mode;
        logic              active;
        logic              configured;
        logic              ist;
        logic              srqs;
        logic              flag;
    } gppr_status_t;

endpackage

// ---- gppr_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module gppr_sync
    import gppr_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    initial begin
        if (W < 1) begin
            $error("gppr_sync: width must be at least one");
        end
    end

    // first stage feeds only the second stage
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule
`default_nettype wire

// ---- gppr_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// controller side: runs polls and sends enable or disable commands
module gppr_ctrl_model
    import gppr_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic [7:0] ppr_msg_i,
    input  wire logic [7:0] ppr_oe_n_i,
    output logic            idy_o,
    output gppr_ctl_t       ctl_o,
    output logic            seen_o,
    output logic [15:0]     val_o
);
    // idle levels at time zero
    initial begin
        idy_o  = 1'b0;
        ctl_o  = '0;
        seen_o = 1'b0;
        val_o  = 16'h0000;
    end

    // one-cycle strobe; byte flips when idle so stale data never matches
    task automatic send(input logic en, input logic [7:0] b);
        @(posedge clock_i);
        ctl_o.ppe      <= en;
        ctl_o.ppd      <= ~en;
        ctl_o.cmd_byte <= b;
        @(posedge clock_i);
        ctl_o.ppe      <= 1'b0;
        ctl_o.ppd      <= 1'b0;
        ctl_o.cmd_byte <= ~b;
    endtask

    // released lines count as not driven, whatever msg shows
    task automatic sample();
        @(posedge clock_i);
        seen_o <= 1'b1;
        val_o  <= {~ppr_oe_n_i, ~ppr_oe_n_i & ppr_msg_i};
        @(posedge clock_i);
        seen_o <= 1'b0;
    endtask

    // idy held past the sync delay, then dropped and the release checked
    task automatic poll();
        @(posedge clock_i);
        idy_o <= 1'b1;
        repeat (5) @(posedge clock_i);
        sample();
        idy_o <= 1'b0;
        repeat (5) @(posedge clock_i);
        sample();
    endtask
endmodule
`default_nettype wire

// ---- tb_gpib_parallel_poll_responder.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("ERROR t=%0t got %h exp %h", $time, g, e); \
    end end
module tb_gpib_parallel_poll_responder
    import gppr_pkg::*;
();
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'hF;
    logic        srqs_i  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idy;
    gppr_ctl_t   ctl;
    logic [7:0]  msg;
    logic [7:0]  oe_n;
    logic        seen;
    logic [15:0] val;
    logic [63:0] q[$];
    int          mismatches = 0;
    int          n_compared = 0;
    logic        flag, status_source_select, srq, m1, m2, cfg, rs, ls;
    logic [2:0]  rl, ll;

    gppr_responder #(.ADDR_W(12)) dut (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .psel_i    (psel),
        .penable_i (penable),
        .pwrite_i  (pwrite),
        .paddr_i   (paddr),
        .pwdata_i  (pwdata),
        .pstrb_i   (pstrb),
        .prdata_o  (prdata),
        .pready_o  (pready),
        .pslverr_o (pslverr),
        .idy_i     (idy),
        .srqs_i    (srqs_i),
        .ctl_i     (ctl),
        .ppr_msg_o (msg),
        .ppr_oe_n_o(oe_n)
    );

    gppr_ctrl_model ctrl (
        .clock_i   (clock_i),
        .ppr_msg_i (msg),
        .ppr_oe_n_i(oe_n),
        .idy_o     (idy),
        .ctl_o     (ctl),
        .seen_o    (seen),
        .val_o     (val)
    );

    // 50 MHz
    initial forever #10 clock_i = ~clock_i;

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic expect_v(input logic [31:0] m, input logic [31:0] v);
        q.push_back({m, v});
    endtask

    // oldest note against whatever result just appeared
    task automatic cmp(input logic [31:0] got);
        logic [63:0] e;
        if (q.size() == 0) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp none", $time, got);
        end else begin
            e = q.pop_front();
            `CHK(got & e[63:32], e[31:0])
        end
    endtask

    // watcher: bus replies carry the error flag in bit 31
    always @(posedge clock_i) begin
        if (psel && penable && pready === 1'b1)
            cmp({pslverr, prdata[30:0]});
        if (seen === 1'b1)
            cmp({16'h0000, val});
    end

    // zero-wait slave still waited on, bounded
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'($urandom()), d};
        pstrb   <= s;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            final_report();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic e);
        expect_v(32'h8000_0000, {e, 31'h0});
        apb(1'b1, a, d, {3'($urandom()), 1'b1});
    endtask

    task automatic wport(input logic [7:0] d);
        wr(12'h028, d, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] v);
        expect_v(m, v);
        apb(1'b0, a, 8'h00, 4'hF);
    endtask

    // status word follows the effective configuration in every mode
    task automatic stat();
        logic [1:0] md;
        md = m1 ? 2'd2 : (m2 ? 2'd1 : 2'd0);
        rd(12'h02C, 32'h8000_07FF,
           {21'h0, m1 ? 3'd0 : (m2 ? ll : rl), !m1 && (m2 ? ls : rs), md,
            1'b0, !m1 && (m2 || cfg), status_source_select ? srq : flag, srq, flag});
    endtask

    function automatic logic [15:0] pp_exp(input logic on);
        logic [7:0] d;
        logic [2:0] ln;
        logic       sn;
        ln = m2 ? ll : rl;
        sn = m2 ? ls : rs;
        d  = (on && !m1 && (m2 || cfg)) ? 8'h01 << ln : 8'h00;
        return {d, ~((status_source_select ? srq : flag) ^ sn) ? d : 8'h00};
    endfunction

    // answer while idy, nothing once it is gone
    task automatic pexp();
        expect_v(32'h0000_FFFF, {16'h0000, pp_exp(1'b1)});
        expect_v(32'h0000_FFFF, {16'h0000, pp_exp(1'b0)});
        ctrl.poll();
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hd53532ee));
        {flag, status_source_select, srq, m1, m2, cfg, rs, ls, rl, ll} = '0;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        stat();
        rd(12'h028, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(12'h100, 32'h8000_0000, 32'h8000_0000);
        wr(12'h02C, 8'h01, 1'b1);
        expect_v(32'h0000_0000, 32'h0000_0000);
        apb(1'b1, 12'h028, 8'h01, 4'hE);
        stat();
        $display("test decode done");
        wport(8'h01);
        flag = 1'b1;
        stat();
        wport(8'h09);
        flag = 1'b0;
        stat();
        $display("test flag done");
        pexp();
        for (int i = 0; i < 8; i++) begin
            flag = 1'($urandom());
            wport(flag ? 8'h01 : 8'h09);
            status_source_select = 1'($urandom());
            wport({3'b101, status_source_select, 4'h0});
            srq = 1'($urandom());
            srqs_i <= srq;
            rs = 1'($urandom());
            rl = 3'(i);
            ctrl.send(1'b1, {4'h6, rs, rl});
            cfg = 1'b1;
            stat();
            pexp();
        end
        ctrl.send(1'b0, 8'h70);
        cfg = 1'b0;
        stat();
        pexp();
        $display("test remote done");
        wport(8'hE4);
        m2 = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ls = 1'($urandom());
            ll = 3'(i);
            wport({3'b011, 1'b0, ls, ll});
            stat();
            pexp();
        end
        ctrl.send(1'b1, {4'h6, ~ls, ~ll});
        pexp();
        $display("test local done");
        wport({3'b011, 1'b1, ls, ll});
        m1 = 1'b1;
        stat();
        pexp();
        wport(8'hE0);
        m2 = 1'b0;
        stat();
        pexp();
        $display("test disabled done");
        for (int i = 0; i < 50 && q.size() != 0; i++)
            @(posedge clock_i);
        if (q.size() != 0)
            mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
